/* analog_reference_control.sv */
// analog reference control register and its analog enables
//
// Contract
// - bit 1 turns the bandgap and converter bias generator on or off.
// - bit 0 turns the gain-of-two reference pin buffer on or off.
// - disabled reference buffer output is released; bandgap and buffer draw little.
// - bits 4 and 3 choose each adc reference independently.
// - alternates are first dac output and analog supply respectively.
// - bit 2 turns the temperature sensor on or off.
// - disabled sensor output released; its conversions flagged undefined.
// - sensor output drives the top input of the first adc mux.
module analog_reference_control
  import analog_reference_pkg::*;
(
  // clock, reset, enable
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst_n,
  input  wire logic                                    clk_en,
  // special function register port
  input  wire logic [analog_reference_pkg::ADDR_W-1:0] sfr_addr,
  input  wire logic                                    sfr_wr,
  input  wire logic [analog_reference_pkg::REG_W-1:0]  sfr_wdata,
  output logic      [analog_reference_pkg::REG_W-1:0]  sfr_rdata,
  output logic                                         sfr_sel,
  // analog enables
  output logic                                         bias_generator_enable,
  output logic                                         reference_buffer_enable,
  output logic                                         ref_buffer_oe_n,
  output logic                                         temp_sensor_enable,
  output logic                                         temp_sensor_oe_n,
  // reference selection
  output logic                                         first_adc_reference_select,
  output logic                                         second_adc_reference_select,
  input  wire logic                                    first_adc_reference_pin,
  input  wire logic                                    second_adc_reference_pin,
  input  wire logic                                    first_dac_output,
  input  wire logic                                    analog_supply,
  output logic                                         first_adc_ref,
  output logic                                         second_adc_ref,
  // first adc mux observation
  input  wire logic [analog_reference_pkg::ADC_MUX_SEL_W-1:0] adc_mux_sel,
  output logic                                         adc_sample_undefined
);
  // one decode shared by the write path, the read path and the write sequences of the checks
  function automatic logic is_control_addr(input logic [ADDR_W-1:0] addr);
    return addr == CONTROL_ADDR;
  endfunction : is_control_addr

  logic [REG_W-1:0] control_q;
  logic [REG_W-1:0] control_d;
  wire              hit = is_control_addr(sfr_addr);
  wire              wr_en = clk_en && sfr_wr && hit;

  assign control_d = wr_en ? (sfr_wdata & CONTROL_WRITE_MASK) : control_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  assign sfr_sel   = hit;
  // unmapped addresses read zero so other sfrs can be or-ed in
  assign sfr_rdata = hit ? control_q : '0;

  assign bias_generator_enable = control_q[BIT_BIAS_GEN_EN];
  assign reference_buffer_enable = control_q[BIT_REF_BUFFER_EN];
  assign ref_buffer_oe_n = ~control_q[BIT_REF_BUFFER_EN];
  assign temp_sensor_enable = control_q[BIT_TEMP_SENSOR_EN];
  assign temp_sensor_oe_n = ~control_q[BIT_TEMP_SENSOR_EN];
  assign first_adc_reference_select  = control_q[BIT_FIRST_ADC_REF_SEL];
  assign second_adc_reference_select = control_q[BIT_SECOND_ADC_REF_SEL];

  // alternates: dac output for the first, supply for the second
  localparam int ADC_CNT = 2;
  logic [ADC_CNT-1:0] ref_sel_vec;
  logic [ADC_CNT-1:0] ref_pin_vec;
  logic [ADC_CNT-1:0] ref_alt_vec;
  logic [ADC_CNT-1:0] ref_out_vec;

  assign ref_sel_vec = {control_q[BIT_SECOND_ADC_REF_SEL], control_q[BIT_FIRST_ADC_REF_SEL]};
  assign ref_pin_vec = {second_adc_reference_pin, first_adc_reference_pin};
  assign ref_alt_vec = {analog_supply, first_dac_output};

  // one mux per adc, no shared select
  for (genvar g = 0; g < ADC_CNT; g++) begin : gen_ref_mux
    ref_source_mux u_mux (
      .sel     (ref_sel_vec[g]),
      .pin_ref (ref_pin_vec[g]),
      .alt_ref (ref_alt_vec[g]),
      .ref_out (ref_out_vec[g])
    );
  end

  assign first_adc_ref  = ref_out_vec[0];
  assign second_adc_ref = ref_out_vec[1];

  assign adc_sample_undefined = (adc_mux_sel == ADC_MUX_TOP_INPUT) &&
                                !control_q[BIT_TEMP_SENSOR_EN];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence write_s;
    clk_en && sfr_wr && is_control_addr(sfr_addr);
  endsequence

  sequence idle_s;
    !(clk_en && sfr_wr && is_control_addr(sfr_addr));
  endsequence

  sequence frozen_write_s;
    !clk_en && sfr_wr && is_control_addr(sfr_addr);
  endsequence

  sequence foreign_write_s;
    clk_en && sfr_wr && !is_control_addr(sfr_addr);
  endsequence

  bias_follows_a: assert property (write_s |=> bias_generator_enable == $past(sfr_wdata[1]))
    else $error("bias enable not loaded");
  buffer_follows_a: assert property (write_s |=> reference_buffer_enable == $past(sfr_wdata[0]))
    else $error("buffer enable not loaded");
  buffer_release_a: assert property (ref_buffer_oe_n == !reference_buffer_enable)
    else $error("buffer release mismatch");
  sensor_follows_a: assert property (write_s |=> temp_sensor_enable == $past(sfr_wdata[2]))
    else $error("sensor enable not loaded");
  select_follows_a: assert property (write_s |=>
      first_adc_reference_select == $past(sfr_wdata[4]) &&
      second_adc_reference_select == $past(sfr_wdata[3]))
    else $error("reference select not loaded");
  alt_route_a: assert property (
      first_adc_reference_select |-> first_adc_ref == first_dac_output
      && (second_adc_reference_select ? second_adc_ref == analog_supply
                                      : second_adc_ref == second_adc_reference_pin))
    else $error("alternate reference misrouted");
  undefined_flag_a: assert property ((adc_mux_sel == 4'hF && !temp_sensor_enable)
      |-> adc_sample_undefined && temp_sensor_oe_n)
    else $error("undefined sample not flagged");
  top_input_a: assert property (adc_sample_undefined |-> adc_mux_sel == 4'hF)
    else $error("undefined flag off top input");
  upper_zero_a: assert property (sfr_sel |-> sfr_rdata[7:5] == 3'h0)
    else $error("upper bits not zero");
  hold_a: assert property (!clk_en |=> $stable(control_q))
    else $error("register changed while frozen");

  // register path
  idle_hold_a: assert property (idle_s |=>
      $stable(control_q))
    else $error("register changed without a write");
  frozen_drop_a: assert property (frozen_write_s |=>
      $stable(control_q))
    else $error("write taken while clock enable low");
  foreign_drop_a: assert property (foreign_write_s |=>
      $stable(control_q))
    else $error("write to other address landed");
  masked_write_a: assert property (write_s |=>
      control_q == $past(sfr_wdata & CONTROL_WRITE_MASK))
    else $error("written value not masked");
  write_then_idle_a: assert property (write_s ##1 idle_s |=>
      control_q == $past(sfr_wdata & CONTROL_WRITE_MASK, 2))
    else $error("written value lost in idle cycle");
  back_to_back_a: assert property (write_s ##1 write_s |=>
      control_q == $past(sfr_wdata & CONTROL_WRITE_MASK))
    else $error("second of two writes not kept");
  change_cause_a: assert property ($changed(control_q) |->
      $past(clk_en && sfr_wr && sfr_addr == CONTROL_ADDR))
    else $error("register changed with no write");
  upper_state_a: assert property (
      control_q[7:5] == 3'h0)
    else $error("upper register bits set");

  // read path
  rdata_match_a: assert property (sfr_sel |->
      sfr_rdata == control_q)
    else $error("read data differs from register");
  rdata_quiet_a: assert property (!sfr_sel |->
      sfr_rdata == 8'h00)
    else $error("unselected read not zero");
  sel_decode_a: assert property (
      sfr_sel == (sfr_addr == CONTROL_ADDR))
    else $error("address hit misdecoded");

  // enables and releases
  frozen_outputs_a: assert property (!clk_en |=>
      $stable({bias_generator_enable, reference_buffer_enable, temp_sensor_enable}))
    else $error("enable moved while frozen");
  sensor_release_a: assert property (
      temp_sensor_oe_n == !temp_sensor_enable)
    else $error("sensor release mismatch");
  reset_idle_a: assert property ($rose(rst_n) |->
      control_q == CONTROL_RESET && ref_buffer_oe_n && temp_sensor_oe_n)
    else $error("outputs not idle after reset");

  // routing and undefined flag
  first_pin_route_a: assert property (!first_adc_reference_select |->
      first_adc_ref == first_adc_reference_pin)
    else $error("first adc pin reference misrouted");
  second_pin_route_a: assert property (!second_adc_reference_select |->
      second_adc_ref == second_adc_reference_pin)
    else $error("second adc pin reference misrouted");
  second_alt_route_a: assert property (second_adc_reference_select |->
      second_adc_ref == analog_supply)
    else $error("second adc supply reference misrouted");
  sensor_defined_a: assert property (temp_sensor_enable |->
      !adc_sample_undefined)
    else $error("enabled sensor flagged undefined");
  other_input_a: assert property (adc_mux_sel != ADC_MUX_TOP_INPUT |->
      !adc_sample_undefined)
    else $error("undefined flag on other input");
endmodule : analog_reference_control

/* analog_reference_pkg.sv */
// constants for the analog reference control register
package analog_reference_pkg;
  localparam int          REG_W                  = 8;
  localparam int          ADDR_W                 = 8;
  localparam logic [7:0]  CONTROL_ADDR           = 8'hD1;
  localparam logic [7:0]  CONTROL_RESET          = 8'h00;
  localparam logic [7:0]  CONTROL_WRITE_MASK     = 8'h1F;
  localparam int          BIT_REF_BUFFER_EN      = 0;
  localparam int          BIT_BIAS_GEN_EN        = 1;
  localparam int          BIT_TEMP_SENSOR_EN     = 2;
  localparam int          BIT_SECOND_ADC_REF_SEL = 3;
  localparam int          BIT_FIRST_ADC_REF_SEL  = 4;
  localparam logic        REF_SEL_PIN            = 1'b0;
  localparam logic        REF_SEL_ALTERNATE      = 1'b1;
  localparam int          ADC_MUX_SEL_W          = 4;
  localparam logic [3:0]  ADC_MUX_TOP_INPUT      = 4'hF;
endpackage : analog_reference_pkg

/* ref_source_mux.sv */
// one adc reference source multiplexer
module ref_source_mux (
  // select
  input  wire logic sel,
  // sources, digital stand-ins for analog levels
  input  wire logic pin_ref,
  input  wire logic alt_ref,
  // result
  output logic      ref_out
);
  import analog_reference_pkg::*;
  assign ref_out = (sel == REF_SEL_ALTERNATE) ? alt_ref : pin_ref;
endmodule : ref_source_mux

/* tb_top.sv */
// self-checking random bench for the analog reference control register
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import analog_reference_pkg::*;
  logic       clk_sys, rst_n, clk_en, sfr_wr, sfr_sel;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ctrl_q, exp_v;
  logic       bias_generator_enable, reference_buffer_enable, ref_buffer_oe_n;
  logic       temp_sensor_enable, temp_sensor_oe_n, first_adc_reference_select;
  logic       second_adc_reference_select, first_adc_reference_pin, second_adc_reference_pin;
  logic       first_dac_output, analog_supply, first_adc_ref, second_adc_ref;
  logic       adc_sample_undefined;
  logic [3:0] adc_mux_sel;
  int         error_cnt, n_compared;
  analog_reference_control u_dut (.clk_sys, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rdata, .sfr_sel, .bias_generator_enable, .reference_buffer_enable, .ref_buffer_oe_n,
    .temp_sensor_enable, .temp_sensor_oe_n, .first_adc_reference_select,
    .second_adc_reference_select, .first_adc_reference_pin, .second_adc_reference_pin,
    .first_dac_output, .analog_supply, .first_adc_ref, .second_adc_ref, .adc_mux_sel,
    .adc_sample_undefined);
  function automatic logic pick(input logic sel, input logic pin, input logic alt);
    return sel ? alt : pin;
  endfunction : pick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // 600 cycles expected, generous margin
  initial begin
    #10000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rst_n, clk_en, sfr_wr, sfr_addr, sfr_wdata, adc_mux_sel} = '0;
    {first_adc_reference_pin, second_adc_reference_pin, first_dac_output, analog_supply} = '0;
    ctrl_q = 8'h00;
    void'($urandom(32'h8939164a));
    for (int i = 0; i < 600; i++) begin
      @(posedge clk_sys);
      // model update: reset wins, only full writes land
      if (!rst_n) ctrl_q = CONTROL_RESET;
      else if (clk_en && sfr_wr && sfr_addr == CONTROL_ADDR) ctrl_q = sfr_wdata & 8'h1F;
      // rare mid-run resets keep the async path busy
      rst_n <= (i >= 8) && ($urandom % 97 != 0);
      clk_en <= ($urandom % 4 != 0);
      sfr_wr <= 1'($urandom);
      sfr_addr <= ($urandom % 3 != 0) ? CONTROL_ADDR : 8'($urandom);
      // corners: all bits set, bias and buffer, bias alone, all off
      sfr_wdata <= (i % 16 == 0) ? 8'hFF : (i % 16 == 4) ? 8'h03 :
        (i % 16 == 8) ? 8'h02 : (i % 16 == 12) ? 8'h00 : 8'($urandom);
      {first_adc_reference_pin, second_adc_reference_pin, first_dac_output, analog_supply,
        adc_mux_sel} <= 8'($urandom);
      @(negedge clk_sys);
      exp_v = rst_n ? ctrl_q : CONTROL_RESET;
      chk(sfr_rdata, (sfr_addr == CONTROL_ADDR) ? exp_v : 8'h00);
      chk(8'(sfr_sel), 8'(sfr_addr == CONTROL_ADDR));
      chk(8'(bias_generator_enable), 8'(exp_v[1]));
      chk(8'({reference_buffer_enable, ref_buffer_oe_n}), 8'({exp_v[0], !exp_v[0]}));
      chk(8'({temp_sensor_enable, temp_sensor_oe_n}), 8'({exp_v[2], !exp_v[2]}));
      chk(8'({first_adc_reference_select, second_adc_reference_select}), 8'(exp_v[4:3]));
      chk(8'(first_adc_ref), 8'(pick(exp_v[4], first_adc_reference_pin, first_dac_output)));
      chk(8'(second_adc_ref), 8'(pick(exp_v[3], second_adc_reference_pin, analog_supply)));
      chk(8'(adc_sample_undefined), 8'(adc_mux_sel == 4'hF && !exp_v[2]));
    end
    give_verdict();
  end
endmodule : tb_top
